// *** logic/e1sc_pkg.sv ***
package e1sc_pkg;
  localparam int E1SC_AW = 11;
  localparam logic [3:0] E1SC_PG_SLOT_LO = 4'h7;
  localparam logic [3:0] E1SC_PG_SLOT_HI = 4'h8;
  localparam logic [3:0] E1SC_PG_TX0 = 4'h9;
  localparam logic [3:0] E1SC_PG_TX1 = 4'hA;
  localparam logic [3:0] E1SC_PG_RX0 = 4'hB;
  localparam logic [3:0] E1SC_PG_RX1 = 4'hC;
  localparam logic [3:0] E1SC_PG_TNAT = 4'hD;
  localparam logic [3:0] E1SC_PG_RNAT = 4'hE;
  localparam logic [3:0] E1SC_PG_CFG = 4'hF;
  localparam logic [4:0] E1SC_OFS_BASE = 5'h10;
  localparam logic [4:0] E1SC_OFS_NAT_LAST = 5'h14;
  localparam logic [4:0] E1SC_OFS_MODE = 5'h10;
  localparam logic [4:0] E1SC_OFS_CINS = 5'h11;
  localparam logic [4:0] E1SC_OFS_CDET = 5'h12;
  localparam logic [4:0] E1SC_OFS_CMSK = 5'h13;
  localparam logic [4:0] E1SC_OFS_TNU = 5'h14;
  localparam logic [4:0] E1SC_OFS_ISTAT = 5'h15;
  localparam logic [4:0] E1SC_OFS_IMASK = 5'h16;
  localparam int E1SC_B_CINS = 7;
  localparam int E1SC_B_CDET = 6;
  localparam int E1SC_B_RLOOP = 5;
  localparam int E1SC_B_LLOOP = 4;
  localparam int E1SC_B_TX0 = 3;
  localparam int E1SC_B_TX1 = 2;
  localparam int E1SC_B_RX0 = 1;
  localparam int E1SC_B_RX1 = 0;
  localparam int E1SC_M_STREAM = 0;
  localparam int E1SC_M_NATIONAL_BUFFER_TX_SELECT = 1;
  localparam int E1SC_M_CRC4 = 2;
  localparam int E1SC_M_SWRST = 3;
  localparam int E1SC_I_CODE = 0;
  localparam int E1SC_I_RNAT = 1;
  localparam logic [7:0] E1SC_MODE_RST = 8'h04;
  localparam logic [7:0] E1SC_BYTE_RST = 8'h00;
  localparam logic [7:0] E1SC_CMSK_RST = 8'hFF;
endpackage

// *** logic/e1sc_slot_ctrl.sv ***
`timescale 1ns/100ps
module e1sc_slot_ctrl (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [e1sc_pkg::E1SC_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_slot_strobe,
  input wire logic [4:0] i_slot_num,
  input wire logic [3:0] i_frame_num,
  input wire logic [7:0] i_line_rx_data,
  input wire logic [7:0] i_backplane_data_input,
  input wire logic [7:0] i_control_stream_input,
  output logic [7:0] o_line_tx_data,
  output logic [7:0] o_backplane_data_output,
  output logic o_slot_valid,
  output logic o_irq
);
  import e1sc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] slot_ctl [32];
  logic [7:0] tx_ring [2][16];
  logic [7:0] rx_ring [2][16];
  logic [7:0] tx_nat_r [5];
  logic [7:0] rx_nat_r [5];
  logic [3:0] act_r [32];
  logic [7:0] mode_r, cins_r, cdet_r, cmsk_r, tnu_r;
  logic [1:0] istat_r, imask_r;
  logic ack_r, swrst_r;
  logic [2:0] odd_cnt_r;

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [3:0] pg;
  logic [4:0] ofs;
  logic hit_slot, hit_tx, hit_rx, hit_tnat, hit_rnat, hit_cfg;
  logic [4:0] slot_idx;
  logic wr_go, rd_go, wr_lane;
  logic [7:0] wbyte, rd_val;
  logic [2:0] nat_idx;

  assign pg = i_avs_address[10:7];
  assign ofs = i_avs_address[6:2];
  assign slot_idx = {pg == E1SC_PG_SLOT_HI, ofs[3:0]};
  assign nat_idx = ofs[2:0];
  assign hit_slot = (pg == E1SC_PG_SLOT_LO || pg == E1SC_PG_SLOT_HI)
                    && ofs >= E1SC_OFS_BASE;
  assign hit_tx = (pg == E1SC_PG_TX0 || pg == E1SC_PG_TX1)
                  && ofs >= E1SC_OFS_BASE;
  assign hit_rx = (pg == E1SC_PG_RX0 || pg == E1SC_PG_RX1)
                  && ofs >= E1SC_OFS_BASE;
  assign hit_tnat = pg == E1SC_PG_TNAT && ofs >= E1SC_OFS_BASE
                    && ofs <= E1SC_OFS_NAT_LAST;
  assign hit_rnat = pg == E1SC_PG_RNAT && ofs >= E1SC_OFS_BASE
                    && ofs <= E1SC_OFS_NAT_LAST;
  assign hit_cfg = pg == E1SC_PG_CFG && ofs >= E1SC_OFS_MODE
                   && ofs <= E1SC_OFS_IMASK;

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr_go = i_avs_write & ack_r;
  assign rd_go = i_avs_read & ~ack_r;
  assign wr_lane = i_avs_byteenable[0];
  assign wbyte = i_avs_writedata[7:0];

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
    end
  end

  always_comb begin
    rd_val = E1SC_BYTE_RST;
    if (hit_slot) begin
      rd_val = slot_ctl[slot_idx];
    end else if (hit_tx) begin
      rd_val = tx_ring[pg == E1SC_PG_TX1][ofs[3:0]];
    end else if (hit_rx) begin
      rd_val = rx_ring[pg == E1SC_PG_RX1][ofs[3:0]];
    end else if (hit_tnat) begin
      rd_val = tx_nat_r[nat_idx];
    end else if (hit_rnat) begin
      rd_val = rx_nat_r[nat_idx];
    end else if (hit_cfg) begin
      unique case (ofs)
        E1SC_OFS_MODE: rd_val = mode_r;
        E1SC_OFS_CINS: rd_val = cins_r;
        E1SC_OFS_CDET: rd_val = cdet_r;
        E1SC_OFS_CMSK: rd_val = cmsk_r;
        E1SC_OFS_TNU: rd_val = tnu_r;
        E1SC_OFS_ISTAT: rd_val = {6'h00, istat_r};
        E1SC_OFS_IMASK: rd_val = {6'h00, imask_r};
        default: rd_val = E1SC_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      o_avs_readdata <= {24'h00_0000, rd_val};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software written storage, only the tx national buffer has reset
  // slot words never reset
  always_ff @(posedge i_mclk) begin
    if (wr_go && wr_lane && hit_slot) begin
      slot_ctl[slot_idx] <= wbyte;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (wr_go && wr_lane && hit_tx) begin
      tx_ring[pg == E1SC_PG_TX1][ofs[3:0]] <= wbyte;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      for (int k = 0; k < 5; k++) begin
        tx_nat_r[k] <= E1SC_BYTE_RST;
      end
    end else if (wr_go && wr_lane && hit_tnat) begin
      tx_nat_r[nat_idx] <= wbyte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration, software reset clears it too
  always_ff @(posedge i_mclk) begin
    if (i_reset || swrst_r) begin
      mode_r <= E1SC_MODE_RST;
      cins_r <= E1SC_BYTE_RST;
      cdet_r <= E1SC_BYTE_RST;
      cmsk_r <= E1SC_CMSK_RST;
      tnu_r <= E1SC_BYTE_RST;
      imask_r <= 2'b00;
    end else if (wr_go && wr_lane && hit_cfg) begin
      unique case (ofs)
        E1SC_OFS_MODE: mode_r <= wbyte;
        E1SC_OFS_CINS: cins_r <= wbyte;
        E1SC_OFS_CDET: cdet_r <= wbyte;
        E1SC_OFS_CMSK: cmsk_r <= wbyte;
        E1SC_OFS_TNU: tnu_r <= wbyte;
        E1SC_OFS_IMASK: imask_r <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  // software reset fires on a rising write of its bit
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      swrst_r <= 1'b0;
    end else begin
      swrst_r <= wr_go && wr_lane && hit_cfg && ofs == E1SC_OFS_MODE
                 && wbyte[E1SC_M_SWRST] && !mode_r[E1SC_M_SWRST];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // slot datapath
  logic stream_mode, proc_mode, national_buffer_tx_select_sel, crc4;
  logic [7:0] ctl_w;
  logic [3:0] act_nxt;
  logic mf_start, match, tx_ring_used, nat_slot;
  logic [2:0] nat_pos;
  logic [7:0] tx_byte, rx_byte;

  assign stream_mode = mode_r[E1SC_M_STREAM];
  assign proc_mode = ~stream_mode;
  assign national_buffer_tx_select_sel = mode_r[E1SC_M_NATIONAL_BUFFER_TX_SELECT];
  assign crc4 = mode_r[E1SC_M_CRC4];
  assign mf_start = i_frame_num == 4'h0;
  assign ctl_w = stream_mode ? i_control_stream_input : slot_ctl[i_slot_num];
  assign act_nxt = mf_start ? ctl_w[3:0] : (act_r[i_slot_num] & ctl_w[3:0]);
  assign match = ((i_line_rx_data ^ cdet_r) & ~cmsk_r) == 8'h00;
  assign tx_ring_used = proc_mode
                        && (act_nxt[E1SC_B_TX0] || act_nxt[E1SC_B_TX1]);
  assign nat_slot = i_slot_num == 5'h00 && i_frame_num[0];
  assign nat_pos = crc4 ? i_frame_num[3:1] : odd_cnt_r;

  always_ff @(posedge i_mclk) begin
    if (i_slot_strobe) begin
      act_r[i_slot_num] <= act_nxt;
    end
  end

  always_comb begin
    tx_byte = i_backplane_data_input;
    if (nat_slot) begin
      for (int n = 0; n < 5; n++) begin
        tx_byte[4-n] = (national_buffer_tx_select_sel && proc_mode) ?
                       tx_nat_r[n][3'h7 - nat_pos] : tnu_r[4-n];
      end
    end
    if (tx_ring_used) begin
      tx_byte = act_nxt[E1SC_B_TX0] ? tx_ring[0][i_frame_num]
                                    : tx_ring[1][i_frame_num];
    end
    if (ctl_w[E1SC_B_RLOOP]) begin
      tx_byte = i_line_rx_data;
    end
    if (ctl_w[E1SC_B_CINS]) begin
      tx_byte = cins_r;
    end
  end

  assign rx_byte = ctl_w[E1SC_B_LLOOP] ? tx_byte : i_line_rx_data;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_line_tx_data <= E1SC_BYTE_RST;
      o_backplane_data_output <= E1SC_BYTE_RST;
      o_slot_valid <= 1'b0;
    end else begin
      o_slot_valid <= i_slot_strobe;
      if (i_slot_strobe) begin
        o_line_tx_data <= tx_byte;
        o_backplane_data_output <= rx_byte;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_slot_strobe && proc_mode) begin
      if (act_nxt[E1SC_B_RX0]) begin
        rx_ring[0][i_frame_num] <= rx_byte;
      end
      if (act_nxt[E1SC_B_RX1]) begin
        rx_ring[1][i_frame_num] <= rx_byte;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_slot_strobe && nat_slot) begin
      for (int n = 0; n < 5; n++) begin
        rx_nat_r[n][3'h7 - nat_pos] <= i_line_rx_data[4-n];
      end
    end
  end

  // consecutive odd frame count when not multiframed
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      odd_cnt_r <= 3'h0;
    end else if (i_slot_strobe && nat_slot) begin
      odd_cnt_r <= crc4 ? 3'h0 : odd_cnt_r + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [1:0] ev, clr;
  assign ev[E1SC_I_CODE] = i_slot_strobe && ctl_w[E1SC_B_CDET] && match;
  assign ev[E1SC_I_RNAT] = i_slot_strobe && nat_slot && nat_pos == 3'h7;
  assign clr = (wr_go && wr_lane && hit_cfg && ofs == E1SC_OFS_ISTAT)
               ? wbyte[1:0] : 2'b00;

  always_ff @(posedge i_mclk) begin
    if (i_reset || swrst_r) begin
      istat_r <= 2'b00;
    end else begin
      istat_r <= (istat_r & ~clr) | ev;
    end
  end

  assign o_irq = |(istat_r & imask_r);

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_bus_one_wait: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    $rose(i_avs_read) && !ack_r |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  chk_code_insert_out: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && ctl_w[E1SC_B_CINS]
    |=> o_line_tx_data == $past(cins_r) && o_slot_valid)
    else $error("code insert word not sent");

  chk_remote_loop_path: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && ctl_w[E1SC_B_RLOOP] && !ctl_w[E1SC_B_CINS]
    && !ctl_w[E1SC_B_LLOOP]
    |=> o_line_tx_data == $past(i_line_rx_data)
        && o_backplane_data_output == o_line_tx_data)
    else $error("remote loopback path wrong");

  chk_local_loop_path: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && ctl_w[E1SC_B_LLOOP]
    |=> o_backplane_data_output == o_line_tx_data)
    else $error("local loopback path wrong");

  chk_detect_cause: assert property (
    @(posedge i_mclk) disable iff (i_reset || swrst_r)
    $rose(istat_r[E1SC_I_CODE])
    |-> $past(i_slot_strobe && ctl_w[E1SC_B_CDET] && match))
    else $error("code detect flag without match");

  chk_detect_sets_irq: assert property (
    @(posedge i_mclk) disable iff (i_reset || swrst_r)
    ev[E1SC_I_CODE] && imask_r[E1SC_I_CODE] && !swrst_r
    |=> istat_r[E1SC_I_CODE] && o_irq)
    else $error("code match did not interrupt");

  chk_ring_proc_only: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && stream_mode && !ctl_w[E1SC_B_CINS]
    && !ctl_w[E1SC_B_RLOOP] && !nat_slot
    |=> o_line_tx_data == $past(i_backplane_data_input))
    else $error("ring used in stream mode");

  chk_tx_ring_pos: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && tx_ring_used && act_nxt[E1SC_B_TX0]
    && ctl_w[7:5] == 3'b000
    |=> o_line_tx_data == $past(tx_ring[0][i_frame_num]))
    else $error("tx ring byte not at frame position");

  chk_nat_word_src: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && nat_slot && !national_buffer_tx_select_sel && !tx_ring_used
    && ctl_w[7:5] == 3'b000
    |=> o_line_tx_data[4:0] == $past(tnu_r[4:0]))
    else $error("national bits not from word");

  chk_rx_ring_rec: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && proc_mode && act_nxt[E1SC_B_RX0]
    && !ctl_w[E1SC_B_LLOOP]
    |=> rx_ring[0][$past(i_frame_num)] == $past(i_line_rx_data))
    else $error("rx ring byte not recorded");

  chk_soft_rst_keep: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    swrst_r && !wr_go
    |=> $stable(tx_nat_r[4]) && mode_r == E1SC_MODE_RST)
    else $error("software reset disturbed national buffer");

  chk_nat_buf_src: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    i_slot_strobe && nat_slot && national_buffer_tx_select_sel && proc_mode && !tx_ring_used
    && ctl_w[7:5] == 3'h0
    |=> o_line_tx_data[4] == $past(tx_nat_r[0][3'h7 - nat_pos]))
    else $error("national bit not from buffer");

  chk_rnat_flag: assert property (
    @(posedge i_mclk) disable iff (i_reset || swrst_r)
    ev[E1SC_I_RNAT]
    |=> istat_r[E1SC_I_RNAT])
    else $error("national buffer completion not flagged");
endmodule

// *** verification/e1sc_bp_model.sv ***
`timescale 1ns/100ps
module e1sc_bp_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  output logic o_strobe,
  output logic [4:0] o_slot,
  output logic [3:0] o_frame,
  output logic [7:0] o_line_rx,
  output logic [7:0] o_bp_in
);
  logic [1:0] gap_r;
  logic [7:0] rx_t;
  logic [7:0] bp_t;
  ////////////////////////////////////////////////////////////////
  // one slot every four clocks, 32 slots a frame
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gap_r <= 2'h0;
      o_strobe <= 1'h0;
      {o_frame, o_slot} <= 9'h1FF;
    end else begin
      gap_r <= gap_r + 2'h1;
      o_strobe <= (gap_r == 2'h3);
      if (gap_r == 2'h3) begin
        {o_frame, o_slot} <= {o_frame, o_slot} + 9'h001;
      end
    end
  end
  // slot bytes, inverted outside the slot
  assign rx_t = {o_frame, o_slot[3:0]} ^ 8'h3C;
  assign bp_t = {o_slot[3:0], o_frame} ^ 8'hC3;
  assign o_line_rx = o_strobe ? rx_t : ~rx_t;
  assign o_bp_in = o_strobe ? bp_t : ~bp_t;
endmodule

// *** verification/e1_slot_ctrl_buffers_tb_top.sv ***
`timescale 1ns/100ps
module e1_slot_ctrl_buffers_tb_top;
  import e1sc_pkg::*;
  logic i_mclk = 1'h0;
  logic i_reset = 1'h1;
  logic [E1SC_AW-1:0] i_avs_address = '0;
  logic i_avs_read = 1'h0;
  logic i_avs_write = 1'h0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [7:0] cs = 8'h00;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_slot_valid, o_irq, stb;
  logic [7:0] o_line_tx_data, o_backplane_data_output, rx_in, bp_in;
  logic [4:0] slot, ls = 5'h0;
  logic [3:0] frame, lf = 4'h0;
  logic [7:0] q, v, e, w, ciw, ring [16], tn [5];
  logic [7:0] tbl [4] = '{8'h00, 8'h80, 8'h20, 8'h10};
  logic [7:0] stm [4] = '{8'h80, 8'h20, 8'h10, 8'h08};
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 3079;
  always #2.5 i_mclk = ~i_mclk;
  e1sc_slot_ctrl e1sc_slot_ctrl_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_slot_strobe(stb),
    .i_slot_num(slot), .i_frame_num(frame), .i_line_rx_data(rx_in),
    .i_backplane_data_input(bp_in), .i_control_stream_input(cs),
    .o_line_tx_data(o_line_tx_data),
    .o_backplane_data_output(o_backplane_data_output),
    .o_slot_valid(o_slot_valid), .o_irq(o_irq));
  e1sc_bp_model e1sc_bp_model_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .o_strobe(stb), .o_slot(slot), .o_frame(frame), .o_line_rx(rx_in),
    .o_bp_in(bp_in));
  always @(posedge i_mclk) begin
    if (stb) begin
      ls <= slot;
      lf <= frame;
    end
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] frx(logic [4:0] s, logic [3:0] f);
    return {f, s[3:0]} ^ 8'h3C;
  endfunction
  function automatic logic [7:0] fbp(logic [4:0] s, logic [3:0] f);
    return {s[3:0], f} ^ 8'hC3;
  endfunction
  function automatic logic [7:0] texp(logic [7:0] c, logic [4:0] s,
    logic [3:0] f);
    return c[7] ? ciw : (c[5] ? frx(s, f) : fbp(s, f));
  endfunction
  task test_done;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task av(logic wr, logic [3:0] pg, logic [4:0] of, logic [7:0] d);
    int n;
    n = 0;
    i_avs_address <= {pg, of, 2'h0};
    i_avs_writedata <= {24'h0, d};
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'h0 && n < 50);
    q = o_avs_readdata[7:0];
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
    @(posedge i_mclk);
    if (n >= 50) begin
      n_errors++;
      test_done();
    end
  endtask
  task rdc(logic [3:0] pg, logic [4:0] of, logic [7:0] exp);
    av(1'h0, pg, of, 8'h00);
    chk(q, exp);
  endtask
  task wcfg(logic [4:0] of, logic [7:0] d);
    av(1'h1, E1SC_PG_CFG, of, d);
  endtask
  task wslot(logic [4:0] s, logic [7:0] d);
    av(1'h1, s[4] ? E1SC_PG_SLOT_HI : E1SC_PG_SLOT_LO, {1'h1, s[3:0]}, d);
  endtask
  task get_slot(logic [4:0] s, logic [3:0] f);
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (!(o_slot_valid === 1'h1 && ls == s && lf == f) && n < 9000);
    if (n >= 9000) begin
      n_errors++;
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'h0;
    @(posedge i_mclk);
    for (int s = 0; s < 32; s++) wslot(5'(s), 8'h00);
    v = $random(seed);
    wslot(5'd3, v);
    wslot(5'd19, ~v);
    rdc(E1SC_PG_SLOT_LO, 5'h13, v);
    rdc(E1SC_PG_SLOT_HI, 5'h13, ~v);
    rdc(4'h0, 5'h10, 8'h00);
    wslot(5'd3, 8'h00);
    wslot(5'd19, 8'h00);
    ciw = $random(seed);
    wcfg(E1SC_OFS_CINS, ciw);
    for (int i = 0; i < 4; i++) begin
      wslot(5'd5, tbl[i]);
      get_slot(5'd5, 4'(i + 2));
      e = tbl[i][4] ? fbp(5, 4'(i + 2)) : frx(5, 4'(i + 2));
      chk(o_line_tx_data, texp(tbl[i], 5, 4'(i + 2)));
      chk(o_backplane_data_output, e);
    end
    wslot(5'd5, 8'h00);
    wcfg(E1SC_OFS_MODE, 8'h05);
    for (int i = 0; i < 4; i++) begin
      cs <= stm[i];
      get_slot(5'd13, 4'(i + 5));
      chk(o_line_tx_data, texp(stm[i], 13, 4'(i + 5)));
    end
    cs <= 8'h00;
    wcfg(E1SC_OFS_MODE, 8'h04);
    wcfg(E1SC_OFS_IMASK, 8'h00);
    wcfg(E1SC_OFS_CMSK, 8'h0F);
    wcfg(E1SC_OFS_CDET, frx(7, 3) ^ 8'h05);
    wcfg(E1SC_OFS_ISTAT, 8'h03);
    wslot(5'd7, 8'h40);
    get_slot(5'd7, 4'h3);
    chk({7'h0, o_irq}, 8'h00);
    wcfg(E1SC_OFS_IMASK, 8'h01);
    chk({7'h0, o_irq}, 8'h01);
    wslot(5'd7, 8'h00);
    wcfg(E1SC_OFS_ISTAT, 8'h01);
    get_slot(5'd7, 4'h3);
    chk({7'h0, o_irq}, 8'h00);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 16; i++) begin
        ring[i] = $random(seed);
        av(1'h1, E1SC_PG_TX0 + 4'(r), 5'h10 + 5'(i), ring[i]);
      end
      wslot(5'd9, 8'h08 >> r);
      get_slot(5'd9, 4'h0);
      for (int i = 1; i < 16; i++) begin
        get_slot(5'd9, 4'(i));
        chk(o_line_tx_data, ring[i]);
      end
      wslot(5'd9, 8'h00);
      wslot(5'd11, 8'h02 >> r);
      get_slot(5'd11, 4'h0);
      get_slot(5'd11, 4'hF);
      wslot(5'd11, 8'h00);
      for (int i = 1; i < 16; i++) begin
        rdc(E1SC_PG_RX0 + 4'(r), 5'h10 + 5'(i), frx(11, 4'(i)));
      end
    end
    for (int n = 0; n < 5; n++) begin
      tn[n] = $random(seed);
      av(1'h1, E1SC_PG_TNAT, 5'h10 + 5'(n), tn[n]);
    end
    wcfg(E1SC_OFS_MODE, 8'h06);
    for (int k = 0; k < 8; k++) begin
      v = fbp(0, 4'(2 * k + 1));
      for (int n = 0; n < 5; n++) v[4 - n] = tn[n][7 - k];
      get_slot(5'd0, 4'(2 * k + 1));
      chk(o_line_tx_data, v);
    end
    for (int n = 0; n < 5; n++) begin
      for (int k = 0; k < 8; k++) begin
        e = frx(0, 4'(2 * k + 1));
        v[7 - k] = e[4 - n];
      end
      rdc(E1SC_PG_RNAT, 5'h10 + 5'(n), v);
    end
    w = $random(seed);
    wcfg(E1SC_OFS_TNU, w);
    wcfg(E1SC_OFS_MODE, 8'h04);
    get_slot(5'd0, 4'h3);
    v = (fbp(0, 3) & 8'hE0) | {3'h0, w[4:0]};
    chk(o_line_tx_data, v);
    v = $random(seed);
    wslot(5'd19, v);
    av(1'h1, E1SC_PG_TNAT, 5'h14, 8'h5A);
    wcfg(E1SC_OFS_MODE, 8'h0C);
    rdc(E1SC_PG_CFG, E1SC_OFS_MODE, E1SC_MODE_RST);
    rdc(E1SC_PG_TNAT, 5'h14, 8'h5A);
    i_reset <= 1'h1;
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'h0;
    @(posedge i_mclk);
    rdc(E1SC_PG_TNAT, 5'h14, 8'h00);
    rdc(E1SC_PG_SLOT_HI, 5'h13, v);
    rdc(E1SC_PG_TX1, 5'h1F, ring[15]);
    test_done();
  end
endmodule
